// ==== hw/aacs_pkg.sv ====
// Constants and types for the step 1 configuration register block of
// the auxiliary converter sequencer.
// Assumes a 32-bit Avalon-MM slave port addressed in bytes.
package aacs_pkg;

   // Register indices and their byte addresses (four bytes per index)
   localparam logic [7:0] CFG_IDX = 8'h91;
   localparam logic [7:0] STAT_IDX = 8'hf0;
   localparam logic [11:0] CFG_ADDR = {2'h0, CFG_IDX, 2'h0};
   localparam logic [11:0] STAT_ADDR = {2'h0, STAT_IDX, 2'h0};

   // Configuration register value after reset and writable bits
   localparam logic [15:0] CFG_RST = 16'h0001;
   localparam logic [15:0] CFG_WMASK = 16'he01f;
   localparam logic [15:0] STAT_RST = 16'h0000;

   // Sequencer step served by this register
   localparam logic [3:0] STEP_ID = 4'h1;

   // Gain select codes and resulting gain factors
   localparam logic [1:0] GAIN_X1 = 2'h0;
   localparam logic [1:0] GAIN_X2 = 2'h1;
   localparam logic [2:0] GAIN_F1 = 3'h1;
   localparam logic [2:0] GAIN_F2 = 3'h2;
   localparam logic [2:0] GAIN_F4 = 3'h4;

   // Positive select codes; internal sources start at POS_INT_MIN
   localparam logic [3:0] POS_EXT_MAX = 4'h7;
   localparam logic [3:0] POS_INT_MIN = 4'h8;
   localparam logic [3:0] POS_TEMP = 4'h8;
   localparam logic [3:0] POS_SHORT = 4'h9;
   localparam logic [3:0] POS_TDAC = 4'ha;
   localparam logic [3:0] POS_RAIL_A = 4'he;
   localparam logic [3:0] POS_RAIL_D = 4'hf;

   // Avalon response codes
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic enable;
      logic [1:0] gain;
      logic [7:0] rsvd;
      logic neg;
      logic [3:0] pos;
   } aacs_cfg_t;

   typedef enum logic [1:0] {
      NEG_GND,
      NEG_EXT7,
      NEG_AUTO
   } aacs_neg_t;

   typedef struct packed {
      logic [2:0] gain_factor;
      aacs_neg_t neg;
      logic [3:0] pos;
      logic internal;
   } aacs_route_t;

endpackage

// ==== hw/aacs_route.sv ====
// Decodes the step 1 configuration fields into converter routing.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module aacs_route
(
   input wire aacs_pkg::aacs_cfg_t cfg_i,
   output aacs_pkg::aacs_route_t route_o
);
   import aacs_pkg::*;

   always_comb
   begin
      route_o.pos = cfg_i.pos;
      route_o.internal = (cfg_i.pos >= POS_INT_MIN);
      // Internal sources pick their own negative input
      if (route_o.internal)
      begin
         route_o.neg = NEG_AUTO;
      end
      else if (cfg_i.neg)
      begin
         route_o.neg = NEG_EXT7;
      end
      else
      begin
         route_o.neg = NEG_GND;
      end
      case (cfg_i.gain)
         GAIN_X1: route_o.gain_factor = GAIN_F1;
         GAIN_X2: route_o.gain_factor = GAIN_F2;
         default: route_o.gain_factor = GAIN_F4;
      endcase
   end

endmodule // aacs_route
`default_nettype wire

// ==== hw/aacs_top.sv ====
// Step 1 configuration register of the auxiliary converter sequencer,
// with an Avalon-MM slave and the step 1 apply/skip logic.
// Assumes the sequencer engine pulses seq_req_i with the step number.
//
// Summary of operation
// - Configuration register resets to 0x0001 and sits at register index 0x91.
// - Bit 15 enables step 1 in the sequence; read/write, resets to zero.
// - Bits 14:13 choose gain: 00 gives 1, 01 gives 2, 10/11 give 4.
// - Bits 12:5 are reserved, read-only and always read back as zero.
// - Bit 4 chooses negative input: 0 analog ground, 1 external input seven.
// - Bits 3:0 choose positive input; 0000-0111 are external inputs; reset 0001.
// - Codes 1000 and up route internal sensors, shorts, test DAC and rails.
// - For internal sources the negative input is automatic; bit 4 ignored.
`timescale 1ns/1ps
`default_nettype none
module aacs_top
(
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [11:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic [1:0] avs_response_o,
   output logic avs_waitrequest_o,
   input wire logic seq_req_i,
   input wire logic [3:0] seq_step_i,
   output logic step1_enable_o,
   output logic step1_apply_o,
   output logic step1_skip_o,
   output aacs_pkg::aacs_route_t step1_route_o
);
   import aacs_pkg::*;

   typedef enum logic {
      ST_IDLE,
      ST_ACK
   } aacs_bus_st_t;

   aacs_bus_st_t bus_st_q;
   aacs_cfg_t cfg_q;
   aacs_cfg_t cfg_d;
   aacs_route_t route_c;
   aacs_route_t route_q;
   logic [31:0] rdata_q;
   logic [1:0] resp_q;
   logic [15:0] rdata_c;
   logic [7:0] apply_cnt_q;
   logic [7:0] skip_cnt_q;
   logic bus_req;
   logic bus_take;
   logic hit_cfg;
   logic hit_stat;
   logic wr_cfg;
   logic wr_stat;
   logic seq_hit;
   logic seq_run;
   logic seq_skip;
   logic apply_q;
   logic skip_q;

   // Bus handshake: one wait state for every access
   assign bus_req = avs_read_i | avs_write_i;
   assign bus_take = bus_req & (bus_st_q == ST_ACK);
   assign avs_waitrequest_o = bus_req & (bus_st_q != ST_ACK);

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bus_st_q <= ST_IDLE;
      end
      else
      begin
         case (bus_st_q)
            ST_IDLE:
            begin
               if (bus_req)
               begin
                  bus_st_q <= ST_ACK;
               end
            end
            default:
            begin
               bus_st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Address decode
   always_comb
   begin
      hit_cfg = 1'b0;
      hit_stat = 1'b0;
      if (avs_address_i == CFG_ADDR)
      begin
         hit_cfg = 1'b1;
      end
      else if (avs_address_i == STAT_ADDR)
      begin
         hit_stat = 1'b1;
      end
   end

   assign wr_cfg = bus_take & avs_write_i & hit_cfg;
   assign wr_stat = bus_take & avs_write_i & hit_stat;

   // Byte-lane merge; reserved bits forced to zero
   always_comb
   begin
      cfg_d = cfg_q;
      if (avs_byteenable_i[0])
      begin
         cfg_d[7:0] = avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1])
      begin
         cfg_d[15:8] = avs_writedata_i[15:8];
      end
      cfg_d = cfg_d & CFG_WMASK;
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cfg_q <= CFG_RST;
      end
      else if (wr_cfg)
      begin
         cfg_q <= cfg_d;
      end
   end

   // Read data and response, captured while waitrequest is high
   always_comb
   begin
      rdata_c = 16'h0000;
      if (hit_cfg)
      begin
         rdata_c = cfg_q & CFG_WMASK;
      end
      else if (hit_stat)
      begin
         rdata_c = {apply_cnt_q, skip_cnt_q};
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rdata_q <= 32'h0000_0000;
         resp_q <= RESP_OK;
      end
      else if (bus_req && bus_st_q == ST_IDLE)
      begin
         rdata_q <= avs_read_i ? {16'h0000, rdata_c} : 32'h0000_0000;
         resp_q <= (hit_cfg || hit_stat) ? RESP_OK : RESP_SLVERR;
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_response_o = resp_q;

   // Step 1 request from the sequencer engine
   assign seq_hit = seq_req_i & (seq_step_i == STEP_ID);
   assign seq_run = seq_hit & cfg_q.enable;
   assign seq_skip = seq_hit & ~cfg_q.enable;

   aacs_route u_route
   (
      .cfg_i(cfg_q),
      .route_o(route_c)
   );

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         apply_q <= 1'b0;
         skip_q <= 1'b0;
      end
      else
      begin
         apply_q <= seq_run;
         skip_q <= seq_skip;
      end
   end

   // Routing held from the last applied step 1
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         route_q <= '0;
      end
      else if (seq_run)
      begin
         route_q <= route_c;
      end
   end

   // Event counters; a count in the clearing cycle survives the clear
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         apply_cnt_q <= STAT_RST[15:8];
         skip_cnt_q <= STAT_RST[7:0];
      end
      else if (wr_stat)
      begin
         apply_cnt_q <= {7'h00, seq_run};
         skip_cnt_q <= {7'h00, seq_skip};
      end
      else
      begin
         apply_cnt_q <= apply_cnt_q + {7'h00, seq_run};
         skip_cnt_q <= skip_cnt_q + {7'h00, seq_skip};
      end
   end

   assign step1_enable_o = cfg_q.enable;
   assign step1_apply_o = apply_q;
   assign step1_skip_o = skip_q;
   assign step1_route_o = route_q;

   // Helper: set once software has written the configuration
   logic cfg_written_q;

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         cfg_written_q <= 1'b0;
      end
      else if (wr_cfg)
      begin
         cfg_written_q <= 1'b1;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   AST_RESET_VALUE: assert property (
      !cfg_written_q |-> (cfg_q == CFG_RST))
      else $error("Config differs from reset value before any write");

   AST_CFG_AT_INDEX: assert property (
      (avs_write_i && !avs_waitrequest_o && avs_address_i == CFG_ADDR
         && avs_byteenable_i[1:0] == 2'h3)
      |=> (cfg_q == ($past(avs_writedata_i[15:0]) & CFG_WMASK)))
      else $error("Full write to config index not stored");

   AST_ENABLE_READ: assert property (
      (avs_read_i && avs_waitrequest_o && avs_address_i == CFG_ADDR)
      ##1 (avs_read_i && !avs_waitrequest_o)
      |-> (avs_readdata_o[15] == cfg_q.enable))
      else $error("Enable bit readback wrong");

   AST_GAIN_MAP: assert property (
      seq_run |=> step1_apply_o && (step1_route_o.gain_factor ==
         (($past(cfg_q.gain) == GAIN_X1) ? GAIN_F1 :
          ($past(cfg_q.gain) == GAIN_X2) ? GAIN_F2 : GAIN_F4)))
      else $error("Gain factor does not follow gain code");

   AST_RSVD_ZERO: assert property (
      (!avs_waitrequest_o && avs_read_i && avs_address_i == CFG_ADDR)
      |-> (avs_readdata_o[12:5] == 8'h00))
      else $error("Reserved bits read non-zero");

   AST_NEG_EXT: assert property (
      (seq_run && cfg_q.pos <= POS_EXT_MAX)
      |=> (step1_route_o.neg == ($past(cfg_q.neg) ? NEG_EXT7 : NEG_GND)))
      else $error("Negative select not honoured for external input");

   AST_POS_FOLLOW: assert property (
      seq_run |=> (step1_route_o.pos == $past(cfg_q.pos))
         && (step1_route_o.internal == ($past(cfg_q.pos) >= POS_INT_MIN)))
      else $error("Positive select not carried to routing");

   AST_INTERNAL_AUTO: assert property (
      (step1_apply_o && step1_route_o.internal)
      |-> (step1_route_o.pos >= POS_INT_MIN) && (step1_route_o.neg == NEG_AUTO))
      else $error("Internal source without automatic negative");

   AST_NEG_IGNORED: assert property (
      (seq_run && cfg_q.pos >= POS_INT_MIN) |=> (step1_route_o.neg == NEG_AUTO))
      else $error("Negative bit used for internal source");

   AST_SKIP_DISABLED: assert property (
      (seq_hit && !cfg_q.enable) |=> step1_skip_o && !step1_apply_o
         && $stable(step1_route_o))
      else $error("Disabled step 1 not skipped");

   AST_OTHER_STEP: assert property (
      (seq_req_i && seq_step_i != STEP_ID) |=> !step1_apply_o && !step1_skip_o
         && $stable(step1_route_o))
      else $error("Step 1 settings used on another step");

   AST_ONE_WAIT: assert property (
      (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("Access not answered after one wait state");

   COV_APPLY: cover property (seq_run ##1 step1_apply_o);
   COV_SKIP: cover property (seq_skip ##1 step1_skip_o);
   COV_TEMP: cover property (seq_run && cfg_q.pos == POS_TEMP);
   COV_UNMAPPED: cover property (bus_take && avs_response_o == RESP_SLVERR);

endmodule // aacs_top
`default_nettype wire

// ==== verif/aacs_top_bench.sv ====
// Self-checking bench for the step 1 configuration register block.
// Drives the Avalon-MM port and the sequencer request port directly.
`timescale 1ns/1ps
`default_nettype none
module aacs_top_bench;
   import aacs_pkg::*;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [11:0] adr = 12'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0] be = 4'h0;
   logic [31:0] rdata;
   logic [1:0] resp;
   logic wait_r;
   logic req = 1'b0;
   logic [3:0] step = 4'h0;
   logic en_o;
   logic apply_o;
   logic skip_o;
   aacs_route_t route_o;
   int error_cnt = 0;
   int check_count = 0;
   integer seed = 84;
   logic [15:0] cfg_m = CFG_RST;
   aacs_route_t route_m = '0;
   logic [7:0] n_app = 8'h0;
   logic [7:0] n_skp = 8'h0;
   logic [33:0] rq[$];
   logic [10:0] sq[$];
   logic [33:0] me;
   logic [10:0] ms;

   aacs_top dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_response_o(resp), .avs_waitrequest_o(wait_r),
      .seq_req_i(req), .seq_step_i(step), .step1_enable_o(en_o),
      .step1_apply_o(apply_o), .step1_skip_o(skip_o), .step1_route_o(route_o));

   always #12.5 ref_clk_i = ~ref_clk_i;

   // Expected routing from a configuration value
   function automatic aacs_route_t mk(input logic [15:0] c);
      aacs_route_t r;
      r.gain_factor = (c[14:13] == GAIN_X1) ? GAIN_F1 : (c[14:13] == GAIN_X2) ? GAIN_F2 : GAIN_F4;
      r.pos = c[3:0];
      r.internal = (c[3:0] >= POS_INT_MIN);
      r.neg = r.internal ? NEG_AUTO : (c[4] ? NEG_EXT7 : NEG_GND);
      return r;
   endfunction

   function automatic logic [33:0] ok(input logic [15:0] d);
      return {RESP_OK, 16'h0, d};
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] b, input logic [33:0] e);
      int n;
      logic [15:0] nv;
      @(posedge ref_clk_i);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wd <= d;
      be <= b;
      if (!w)
         rq.push_back(e);
      n = 0;
      @(posedge ref_clk_i);
      while (wait_r !== 1'b0 && n < 50)
      begin
         n++;
         @(posedge ref_clk_i);
      end
      if (n == 50)
         chk("waitrequest timeout", 32'h0, 32'h1);
      rd <= 1'b0;
      wr <= 1'b0;
      nv = (cfg_m & ~CFG_WMASK) | (d[15:0] & CFG_WMASK);
      if (w && a == CFG_ADDR && b[0])
         cfg_m[7:0] = nv[7:0];
      if (w && a == CFG_ADDR && b[1])
         cfg_m[15:8] = nv[15:8];
      if (w && a == STAT_ADDR)
      begin
         n_app = 8'h0;
         n_skp = 8'h0;
      end
   endtask

   task automatic seq_go(input logic [3:0] s);
      @(posedge ref_clk_i);
      chk("step1_enable_o", {31'h0, cfg_m[15]}, {31'h0, en_o});
      req <= 1'b1;
      step <= s;
      if (s == STEP_ID && cfg_m[15])
      begin
         route_m = mk(cfg_m);
         n_app++;
      end
      else if (s == STEP_ID)
         n_skp++;
      if (s == STEP_ID)
         sq.push_back({cfg_m[15], route_m});
      @(posedge ref_clk_i);
      req <= 1'b0;
   endtask

   task automatic do_reset();
      @(posedge ref_clk_i);
      arst_n_i <= 1'b0;
      repeat (12) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      cfg_m = CFG_RST;
      route_m = '0;
      n_app = 8'h0;
      n_skp = 8'h0;
   endtask

   // Result watcher: oldest note against each answer
   always @(posedge ref_clk_i)
   begin
      if (rd && wait_r === 1'b0 && rq.size() > 0)
      begin
         me = rq.pop_front();
         chk("readdata", me[31:0], rdata);
         chk("response", {30'h0, me[33:32]}, {30'h0, resp});
      end
      if (apply_o !== 1'b0 || skip_o !== 1'b0)
      begin
         if (sq.size() == 0)
            chk("unexpected step pulse", 32'h0, 32'h1);
         else
         begin
            ms = sq.pop_front();
            chk("step1_apply_o", {31'h0, ms[10]}, {31'h0, apply_o});
            chk("step1_skip_o", {31'h0, ~ms[10]}, {31'h0, skip_o});
            chk("step1_route_o", {22'h0, ms[9:0]}, {22'h0, route_o});
         end
      end
   end

   task automatic final_report();
      chk("pending results", 32'h0, rq.size() + sq.size());
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #500000;
      error_cnt++;
      final_report();
   end

   initial
   begin
      repeat (12) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      bus(1'b0, CFG_ADDR, 32'h0, 4'hf, ok(CFG_RST));
      bus(1'b0, STAT_ADDR, 32'h0, 4'hf, ok(STAT_RST));
      seq_go(STEP_ID);
      for (int i = 0; i < 128; i++)
      begin
         bus(1'b1, CFG_ADDR, {16'hffff, 1'b1, i[5:4], 8'hff, i[6], i[3:0]}, 4'hf, '0);
         bus(1'b0, CFG_ADDR, 32'h0, 4'hf, ok(cfg_m));
         seq_go(STEP_ID);
      end
      for (int i = 0; i < 40; i++)
      begin
         bus(1'b1, CFG_ADDR, $random(seed), 4'($random(seed)), '0);
         bus(1'b0, CFG_ADDR, 32'h0, 4'hf, ok(cfg_m));
         seq_go(4'($random(seed)));
         seq_go(STEP_ID);
      end
      bus(1'b0, STAT_ADDR, 32'h0, 4'hf, ok({n_app, n_skp}));
      bus(1'b1, STAT_ADDR, 32'h0, 4'hf, '0);
      bus(1'b0, STAT_ADDR, 32'h0, 4'hf, ok(16'h0));
      bus(1'b1, CFG_ADDR + 12'h4, 32'hffff, 4'hf, '0);
      bus(1'b0, CFG_ADDR + 12'h4, 32'h0, 4'hf, {RESP_SLVERR, 32'h0});
      bus(1'b0, CFG_ADDR, 32'h0, 4'hf, ok(cfg_m));
      do_reset();
      bus(1'b0, CFG_ADDR, 32'h0, 4'hf, ok(CFG_RST));
      seq_go(STEP_ID);
      repeat (4) @(posedge ref_clk_i);
      final_report();
   end
endmodule // aacs_top_bench
`default_nettype wire
